// ===== ipv4c_classifier.sv
// IPv4 access entry classifier: configuration, entry scan and verdict
//
// Overview of operation
// - Permit verdict forwards the frame and lets its source address be learned.
// - Deny verdict drops the frame; it is neither forwarded nor delivered.
// - Verdict field also encodes shutdown besides permit and deny.
// - Protocol selector any makes the IP protocol field don't-care.
// - Specific protocol selector matches only frames with that protocol value.
// - Source address filter any skips the source address compare.
// - User source filter compares source address under the source wildcard mask.
// - Each entry stores a 32-bit source wildcard mask beside the address.
// - Destination address filter any skips the destination address compare.
// - User destination filter compares under the destination wildcard mask.
// - Each entry stores a 32-bit destination wildcard mask beside the address.
// - Source port selector any makes the source port don't-care.
// - Single source port selector matches only an equal 16-bit port.
// - Range source port selector matches ports inside the stored bounds.
// - Each entry carries a sequence number and its list reference.
// - Entries that exceed hardware resources are marked as conflicts.
// - A direct protocol identifier is an 8-bit value 0 to 255.
`timescale 1ns/1ps
`include "ipv4c_defines.svh"
module ipv4c_classifier
    import ipv4c_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cfg_wr_valid,
    input wire logic [2:0] cfg_wr_idx,
    input wire ipv4c_access_entry_t cfg_wr_entry,
    output logic cfg_ready,
    input wire logic [7:0] bind_list,
    input wire logic frm_valid,
    input wire ipv4c_frame_t frm_in,
    output logic frm_ready,
    output ipv4c_verdict_t verdict,
    output logic [7:0] conflict
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        ipv4c_state_t state;
        logic idle;
        ipv4c_frame_t frame;
        logic [7:0] list;
        logic [2:0] addr;
        logic eval_vld;
        logic [2:0] eval_idx;
        logic found;
        logic [15:0] best_seq;
        ipv4c_act_t best_act;
        logic [2:0] best_idx;
        logic [7:0] conflict;
        logic [7:0] range_used;
        ipv4c_verdict_t vrd;
    } ipv4c_main_st_t;
    ipv4c_main_st_t st_ff;
    ipv4c_main_st_t nxt_st;

    logic cfg_take;
    logic frm_take;
    logic need_range;
    logic [7:0] range_other;
    logic [3:0] range_count;
    logic new_conflict;
    ipv4c_access_entry_t wr_entry;
    ipv4c_access_entry_t rd_entry;
    logic hit;

    // ----------------------------------------
    // Entry storage and matcher
    // ----------------------------------------
    ipv4c_entry_mem u_mem (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .wr_en(cfg_take),
        .wr_idx(cfg_wr_idx),
        .wr_entry(wr_entry),
        .rd_idx(st_ff.addr),
        .rd_entry(rd_entry)
    );

    ipv4c_entry_match u_match (
        .entry(rd_entry),
        .frame(st_ff.frame),
        .list_id(st_ff.list),
        .hit(hit)
    );

    // Range units held by entries other than the one being written
    genvar gi;
    generate
        for (gi = 0; gi < `IPV4C_ENTRIES; gi++) begin : g_range
            assign range_other[gi] = st_ff.range_used[gi] && (cfg_wr_idx != 3'(gi));
        end
    endgenerate

    // Configuration takes priority over a frame in the idle state
    always_comb begin
        cfg_take = cfg_wr_valid && st_ff.idle;
        frm_take = frm_valid && st_ff.idle && !cfg_wr_valid;
        need_range = cfg_wr_entry.valid && (cfg_wr_entry.sport_sel == IPV4C_PORT_RANGE);
        range_count = 4'($countones(range_other));
        new_conflict = need_range && (range_count >= `IPV4C_RANGE_UNITS);
        wr_entry = cfg_wr_entry;
        wr_entry.valid = cfg_wr_entry.valid && !new_conflict;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.vrd = '0;
        nxt_st.eval_vld = (st_ff.state == IPV4C_SCAN);
        nxt_st.eval_idx = st_ff.addr;
        // Record install result and range usage of a written entry
        if (cfg_take) begin
            nxt_st.conflict[cfg_wr_idx] = new_conflict;
            nxt_st.range_used[cfg_wr_idx] = need_range && !new_conflict;
        end
        // Keep the matching entry with the lowest sequence number
        if (st_ff.eval_vld && hit && (!st_ff.found || (rd_entry.seq < st_ff.best_seq))) begin
            nxt_st.found = 1'b1;
            nxt_st.best_seq = rd_entry.seq;
            nxt_st.best_act = rd_entry.action;
            nxt_st.best_idx = st_ff.eval_idx;
        end
        case (st_ff.state)
            IPV4C_IDLE: begin
                if (frm_take) begin
                    nxt_st.frame = frm_in;
                    nxt_st.list = bind_list;
                    nxt_st.found = 1'b0;
                    nxt_st.addr = `IPV4C_FIRST_IDX;
                    nxt_st.idle = 1'b0;
                    nxt_st.state = IPV4C_SCAN;
                end
            end
            IPV4C_SCAN: begin
                if (st_ff.addr == `IPV4C_LAST_IDX) begin
                    nxt_st.state = IPV4C_LAST;
                end else begin
                    nxt_st.addr = st_ff.addr + 3'h1;
                end
            end
            IPV4C_LAST: begin
                // Last entry is evaluated now; issue the verdict
                nxt_st.vrd.valid = 1'b1;
                nxt_st.vrd.hit = nxt_st.found;
                // No match reports slot zero, never a slot left from an earlier frame
                nxt_st.vrd.idx = nxt_st.found ? nxt_st.best_idx : `IPV4C_FIRST_IDX;
                if (!nxt_st.found) begin
                    nxt_st.vrd.forward = 1'b1;
                    nxt_st.vrd.learn = 1'b1;
                end else begin
                    case (nxt_st.best_act)
                        IPV4C_ACT_PERMIT: begin
                            nxt_st.vrd.forward = 1'b1;
                            nxt_st.vrd.learn = 1'b1;
                        end
                        IPV4C_ACT_DENY: begin
                            nxt_st.vrd.drop = 1'b1;
                        end
                        IPV4C_ACT_SHUTDOWN: begin
                            nxt_st.vrd.drop = 1'b1;
                            nxt_st.vrd.shutdown = 1'b1;
                        end
                        default: begin
                            nxt_st.vrd.drop = 1'b1;
                        end
                    endcase
                end
                nxt_st.addr = `IPV4C_FIRST_IDX;
                nxt_st.idle = 1'b1;
                nxt_st.state = IPV4C_IDLE;
            end
            default: begin
                nxt_st.idle = 1'b1;
                nxt_st.state = IPV4C_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
            st_ff.idle <= 1'b1;
            st_ff.state <= IPV4C_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cfg_ready = st_ff.idle;
    assign frm_ready = st_ff.idle;
    assign verdict = st_ff.vrd;
    assign conflict = st_ff.conflict;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    localparam int SCAN_LAT = `IPV4C_SCAN_LAT;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // Verdict flags against the winning entry's action, which stands registered in the pulse cycle, and on a miss; pulse shape
    chk_permit_fwd: assert property (verdict.valid && verdict.hit && st_ff.best_act == IPV4C_ACT_PERMIT
        |-> verdict.forward && verdict.learn && !verdict.drop) else $error("permit did not forward");
    chk_deny_drop: assert property (verdict.valid && verdict.hit && st_ff.best_act == IPV4C_ACT_DENY
        |-> verdict.drop && !verdict.forward && !verdict.learn) else $error("deny did not drop");
    chk_shut_flag: assert property (verdict.valid && verdict.hit && st_ff.best_act == IPV4C_ACT_SHUTDOWN
        |-> verdict.shutdown && verdict.drop) else $error("shutdown not flagged");
    chk_shut_only: assert property (verdict.shutdown |-> verdict.valid && verdict.drop && !verdict.forward)
        else $error("shutdown without drop");
    chk_miss_pass: assert property (verdict.valid && !verdict.hit
        |-> verdict.forward && verdict.learn && !verdict.drop && verdict.idx == 3'h0) else $error("miss not passed");
    chk_idle_quiet: assert property (!verdict.valid |-> verdict == '0)
        else $error("verdict flags outside pulse");
    chk_one_pulse: assert property (verdict.valid |=> !verdict.valid)
        else $error("verdict longer than a cycle");

    // Field filters of the entry under evaluation
    chk_proto_miss: assert property (st_ff.eval_vld && !rd_entry.proto_any
        && rd_entry.proto != st_ff.frame.proto |-> !hit) else $error("protocol mismatch hit");
    chk_proto_hit: assert property (st_ff.eval_vld && rd_entry.valid && rd_entry.list_id == st_ff.list
        && !rd_entry.proto_any && rd_entry.proto == st_ff.frame.proto
        && rd_entry.src_ip_any && rd_entry.dst_ip_any && rd_entry.sport_sel == IPV4C_PORT_ANY
        |-> hit) else $error("protocol match missed");
    chk_all_any_hit: assert property (st_ff.eval_vld && rd_entry.valid && rd_entry.list_id == st_ff.list
        && rd_entry.proto_any && rd_entry.src_ip_any && rd_entry.dst_ip_any && rd_entry.sport_sel == IPV4C_PORT_ANY
        |-> hit) else $error("wildcard entry missed");
    chk_src_mask: assert property (st_ff.eval_vld && !rd_entry.src_ip_any
        && ((st_ff.frame.src_ip ^ rd_entry.src_ip) & ~rd_entry.source_ip_mask) != '0 |-> !hit)
        else $error("source hit");
    chk_dst_mask: assert property (st_ff.eval_vld && !rd_entry.dst_ip_any
        && ((st_ff.frame.dst_ip ^ rd_entry.dst_ip) & ~rd_entry.destination_ip_mask) != '0 |-> !hit)
        else $error("dest hit");
    chk_range_in: assert property (st_ff.eval_vld && rd_entry.valid && rd_entry.list_id == st_ff.list
        && rd_entry.proto_any && rd_entry.src_ip_any && rd_entry.dst_ip_any
        && rd_entry.sport_sel == IPV4C_PORT_RANGE
        && st_ff.frame.sport >= rd_entry.sport_lo && st_ff.frame.sport <= rd_entry.sport_hi |-> hit)
        else $error("port inside range missed");
    chk_list_miss: assert property (st_ff.eval_vld && rd_entry.list_id != st_ff.list |-> !hit)
        else $error("entry of another list hit");
    chk_invalid_miss: assert property (st_ff.eval_vld && !rd_entry.valid |-> !hit)
        else $error("invalid entry hit");
    chk_port_range: assert property (st_ff.eval_vld && rd_entry.sport_sel == IPV4C_PORT_RANGE
        && (st_ff.frame.sport < rd_entry.sport_lo || st_ff.frame.sport > rd_entry.sport_hi) |-> !hit)
        else $error("port outside range hit");
    chk_port_single: assert property (st_ff.eval_vld && rd_entry.sport_sel == IPV4C_PORT_SINGLE
        && st_ff.frame.sport != rd_entry.sport_lo |-> !hit) else $error("single port mismatch hit");

    // Winner selection over the scan
    chk_found_set: assert property (st_ff.eval_vld && hit |=> st_ff.found)
        else $error("hit not recorded");
    chk_lowest_seq: assert property (st_ff.eval_vld && hit && st_ff.found && rd_entry.seq < st_ff.best_seq
        |=> st_ff.best_idx == $past(st_ff.eval_idx)) else $error("lower sequence not kept");

    // Install results; a scan never touches them
    chk_conflict_set: assert property (cfg_take && need_range && range_count >= `IPV4C_RANGE_UNITS
        |=> conflict[$past(cfg_wr_idx)]) else $error("conflict not flagged");
    chk_conflict_clr: assert property (cfg_take && !need_range |=> !conflict[$past(cfg_wr_idx)])
        else $error("conflict not cleared");
    chk_busy_stable: assert property (!cfg_ready |=> $stable(conflict))
        else $error("conflict changed during scan");

    // Frame timing: busy for nine cycles, verdict in the tenth after the accept edge
    chk_scan_time: assert property (frm_take |-> ##SCAN_LAT (verdict.valid && frm_ready))
        else $error("verdict latency wrong");
    chk_busy_hold: assert property (frm_take |=> !frm_ready[*8] ##1 (!frm_ready && !verdict.valid))
        else $error("ready during scan");

    cov_permit: cover property (verdict.valid && verdict.forward && verdict.hit);
    cov_deny: cover property (verdict.valid && verdict.drop && !verdict.shutdown);
    cov_conflict: cover property (cfg_take && new_conflict);
    cov_reorder: cover property (st_ff.eval_vld && hit && st_ff.found && rd_entry.seq < st_ff.best_seq);
    cov_shutdown: cover property (verdict.valid && verdict.shutdown);
endmodule

// ===== ipv4c_defines.svh
// Constants of the IPv4 access entry classifier
`ifndef IPV4C_DEFINES_SVH
`define IPV4C_DEFINES_SVH
// ----------------------------------------
// Table geometry and resource limits
// ----------------------------------------
`define IPV4C_ENTRIES 8
`define IPV4C_LAST_IDX 3'h7
`define IPV4C_FIRST_IDX 3'h0
`define IPV4C_RANGE_UNITS 4'h4
// Accept edge to verdict pulse, in cycles
`define IPV4C_SCAN_LAT 10
`endif

// ===== ipv4c_entry_match.sv
// Compares one frame against one access entry
`timescale 1ns/1ps
module ipv4c_entry_match
    import ipv4c_pkg::*;
(
    input wire ipv4c_access_entry_t entry,
    input wire ipv4c_frame_t frame,
    input wire logic [7:0] list_id,
    output logic hit
);
    logic proto_ok;
    logic src_ok;
    logic dst_ok;
    logic sport_ok;

    // Field filters; mask ones are don't-care address bits
    always_comb begin
        proto_ok = entry.proto_any || (frame.proto == entry.proto);
        src_ok = entry.src_ip_any
            || (((frame.src_ip ^ entry.src_ip) & ~entry.source_ip_mask) == '0);
        dst_ok = entry.dst_ip_any
            || (((frame.dst_ip ^ entry.dst_ip) & ~entry.destination_ip_mask) == '0);
        case (entry.sport_sel)
            IPV4C_PORT_ANY: sport_ok = 1'b1;
            IPV4C_PORT_SINGLE: sport_ok = (frame.sport == entry.sport_lo);
            IPV4C_PORT_RANGE: sport_ok = (frame.sport >= entry.sport_lo) && (frame.sport <= entry.sport_hi);
            default: sport_ok = 1'b0;
        endcase
        // All enabled filters at once, and only entries of the bound list
        hit = entry.valid && (entry.list_id == list_id) && proto_ok && src_ok && dst_ok && sport_ok;
    end
endmodule

// ===== ipv4c_entry_mem.sv
// Access entry storage with registered read data
`timescale 1ns/1ps
`include "ipv4c_defines.svh"
module ipv4c_entry_mem
    import ipv4c_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire ipv4c_access_entry_t wr_entry,
    input wire logic [2:0] rd_idx,
    output ipv4c_access_entry_t rd_entry
);
    typedef struct packed {
        ipv4c_access_entry_t [`IPV4C_ENTRIES-1:0] mem;
        ipv4c_access_entry_t rd;
    } ipv4c_mem_st_t;
    ipv4c_mem_st_t st_ff;
    ipv4c_mem_st_t nxt_st;

    // Write one entry, read one entry every cycle
    always_comb begin
        nxt_st = st_ff;
        if (wr_en) begin
            nxt_st.mem[wr_idx] = wr_entry;
        end
        nxt_st.rd = st_ff.mem[rd_idx];
    end

    // State register, all entries invalid after reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rd_entry = st_ff.rd;
endmodule

// ===== ipv4c_fwd_model.sv
// Forwarding and learning logic model that consumes classifier verdicts
`timescale 1ns/1ps
module ipv4c_fwd_model
    import ipv4c_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire ipv4c_verdict_t verdict,
    output logic [7:0] fwd_cnt,
    output logic [7:0] drop_cnt
);
    // ----------------------------------------
    // Verdict intake
    // ----------------------------------------
    // Counts only frames with a valid verdict; flags outside the pulse are ignored
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            fwd_cnt <= 8'h00;
            drop_cnt <= 8'h00;
        end else if (verdict.valid) begin
            if (verdict.forward && verdict.learn) begin
                fwd_cnt <= fwd_cnt + 8'h01;
            end
            if (verdict.drop) begin
                drop_cnt <= drop_cnt + 8'h01;
            end
        end
    end
endmodule

// ===== ipv4c_pkg.sv
// Types shared by the IPv4 access entry classifier
package ipv4c_pkg;
    typedef enum logic [1:0] {IPV4C_ACT_PERMIT, IPV4C_ACT_DENY, IPV4C_ACT_SHUTDOWN} ipv4c_act_t;
    typedef enum logic [1:0] {IPV4C_PORT_ANY, IPV4C_PORT_SINGLE, IPV4C_PORT_RANGE} ipv4c_port_sel_t;
    typedef enum logic [1:0] {IPV4C_IDLE, IPV4C_SCAN, IPV4C_LAST} ipv4c_state_t;
    typedef struct packed {
        logic valid;
        logic [7:0] list_id;
        logic [15:0] seq;
        ipv4c_act_t action;
        logic proto_any;
        logic [7:0] proto;
        logic src_ip_any;
        logic [31:0] src_ip;
        logic [31:0] source_ip_mask;
        logic dst_ip_any;
        logic [31:0] dst_ip;
        logic [31:0] destination_ip_mask;
        ipv4c_port_sel_t sport_sel;
        logic [15:0] sport_lo;
        logic [15:0] sport_hi;
    } ipv4c_access_entry_t;
    typedef struct packed {
        logic [7:0] proto;
        logic [31:0] src_ip;
        logic [31:0] dst_ip;
        logic [15:0] sport;
    } ipv4c_frame_t;
    typedef struct packed {
        logic valid;
        logic hit;
        logic forward;
        logic learn;
        logic drop;
        logic shutdown;
        logic [2:0] idx;
    } ipv4c_verdict_t;
endpackage

// ===== tb_top.sv
// Self-checking testbench of the IPv4 access entry classifier
`timescale 1ns/1ps
module tb_top
    import ipv4c_pkg::*;
;
    logic sys_clk;
    logic rstn;
    logic cfg_wr_valid;
    logic [2:0] cfg_wr_idx;
    ipv4c_access_entry_t cfg_wr_entry;
    logic cfg_ready;
    logic [7:0] bind_list;
    logic frm_valid;
    ipv4c_frame_t frm_in;
    logic frm_ready;
    ipv4c_verdict_t verdict;
    logic [7:0] conflict;
    logic [7:0] fwd_cnt;
    logic [7:0] drop_cnt;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [7:0] exp_fwd = 8'h00;
    logic [7:0] exp_drop = 8'h00;
    ipv4c_access_entry_t e;

    ipv4c_classifier dut (.sys_clk(sys_clk), .rstn(rstn), .cfg_wr_valid(cfg_wr_valid), .cfg_wr_idx(cfg_wr_idx),
        .cfg_wr_entry(cfg_wr_entry), .cfg_ready(cfg_ready), .bind_list(bind_list), .frm_valid(frm_valid),
        .frm_in(frm_in), .frm_ready(frm_ready), .verdict(verdict), .conflict(conflict));
    ipv4c_fwd_model fwd (.sys_clk(sys_clk), .rstn(rstn), .verdict(verdict), .fwd_cnt(fwd_cnt), .drop_cnt(drop_cnt));

    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // About 26 operations of at most 10 cycles fit well below this ceiling
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            complete_run();
        end
    end

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Match-all entry of list 5 with sequence 0 and permit
    function automatic ipv4c_access_entry_t base();
        ipv4c_access_entry_t b;
        b = '0;
        b.valid = 1'b1;
        b.list_id = 8'h05;
        b.proto_any = 1'b1;
        b.src_ip_any = 1'b1;
        b.dst_ip_any = 1'b1;
        b.action = IPV4C_ACT_PERMIT;
        b.sport_sel = IPV4C_PORT_ANY;
        return b;
    endfunction

    // Writes one slot and checks its conflict flag; an idle cycle follows
    task automatic wr(input logic [2:0] ix, input ipv4c_access_entry_t en, input logic cf);
        cfg_wr_idx = ix;
        cfg_wr_entry = en;
        cfg_wr_valid = 1'b1;
        @(posedge sys_clk);
        #1 cfg_wr_valid = 1'b0;
        chk("conflict bit", 32'(cf), 32'(conflict[ix]));
        @(posedge sys_clk);
        #1;
    endtask

    // Offers one frame and checks the verdict pulse exactly ten cycles later
    task automatic frame(input logic [7:0] pr, input logic [31:0] s, input logic [31:0] d, input logic [15:0] sp,
        input logic [7:0] lst, input logic h, input ipv4c_act_t a, input logic [2:0] ix);
        ipv4c_verdict_t ev;
        ev = '0;
        ev.valid = 1'b1;
        ev.hit = h;
        ev.forward = !h || (a == IPV4C_ACT_PERMIT);
        ev.learn = ev.forward;
        ev.drop = !ev.forward;
        ev.shutdown = h && (a == IPV4C_ACT_SHUTDOWN);
        ev.idx = h ? ix : 3'h0;
        frm_in = '{proto: pr, src_ip: s, dst_ip: d, sport: sp};
        bind_list = lst;
        frm_valid = 1'b1;
        @(posedge sys_clk);
        #1 frm_valid = 1'b0;
        chk("frm_ready busy", 32'h0, 32'(frm_ready));
        chk("cfg_ready busy", 32'h0, 32'(cfg_ready));
        repeat (8) @(posedge sys_clk);
        #1 chk("verdict early", 32'h0, 32'(verdict));
        chk("frm_ready late", 32'h0, 32'(frm_ready));
        @(posedge sys_clk);
        #1 chk("verdict", 32'(ev), 32'(verdict));
        chk("frm_ready idle", 32'h1, 32'(frm_ready));
        exp_fwd += {7'h00, ev.forward};
        exp_drop += {7'h00, ev.drop};
    endtask

    task automatic complete_run();
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        cfg_wr_valid = 1'b0;
        cfg_wr_idx = 3'h0;
        cfg_wr_entry = '0;
        bind_list = 8'h00;
        frm_valid = 1'b0;
        frm_in = '0;
        repeat (2) @(posedge sys_clk);
        #1 rstn = 1'b1;
        chk("reset verdict", 32'h0, 32'(verdict));
        chk("reset conflict", 32'h0, 32'(conflict));
        chk("reset ready", 32'h1, 32'(cfg_ready & frm_ready));
        // Empty table passes by default
        frame(8'h06, 32'h0A000033, 32'h01020304, 16'h1234, 8'h05, 1'b0, IPV4C_ACT_PERMIT, 3'h0);
        // Protocol and masked source address filter in slot 2
        e = base();
        e.seq = 16'h000A;
        e.proto_any = 1'b0;
        e.proto = 8'h06;
        e.src_ip_any = 1'b0;
        e.src_ip = 32'h0A000000;
        e.source_ip_mask = 32'h000000FF;
        wr(3'h2, e, 1'b0);
        frame(8'h06, 32'h0A000033, 32'h01020304, 16'h1234, 8'h05, 1'b1, IPV4C_ACT_PERMIT, 3'h2);
        frame(8'h11, 32'h0A000033, 32'h01020304, 16'h1234, 8'h05, 1'b0, IPV4C_ACT_PERMIT, 3'h0);
        frame(8'h06, 32'h0A000133, 32'h01020304, 16'h1234, 8'h05, 1'b0, IPV4C_ACT_PERMIT, 3'h0);
        frame(8'h06, 32'h0A000033, 32'h01020304, 16'h1234, 8'h04, 1'b0, IPV4C_ACT_PERMIT, 3'h0);
        // Deny on masked destination and single port in slot 1
        e = base();
        e.seq = 16'h0005;
        e.action = IPV4C_ACT_DENY;
        e.dst_ip_any = 1'b0;
        e.dst_ip = 32'hC0A80100;
        e.destination_ip_mask = 32'h000000FF;
        e.sport_sel = IPV4C_PORT_SINGLE;
        e.sport_lo = 16'h0050;
        wr(3'h1, e, 1'b0);
        frame(8'h06, 32'h0A000033, 32'hC0A801FE, 16'h0050, 8'h05, 1'b1, IPV4C_ACT_DENY, 3'h1);
        frame(8'h06, 32'h0A000033, 32'hC0A801FE, 16'h0051, 8'h05, 1'b1, IPV4C_ACT_PERMIT, 3'h2);
        frame(8'h06, 32'h0A000033, 32'hC0A802FE, 16'h0050, 8'h05, 1'b1, IPV4C_ACT_PERMIT, 3'h2);
        // Higher sequence in the lower slot loses
        e.seq = 16'h0014;
        wr(3'h1, e, 1'b0);
        frame(8'h06, 32'h0A000033, 32'hC0A801FE, 16'h0050, 8'h05, 1'b1, IPV4C_ACT_PERMIT, 3'h2);
        // Shutdown with a port range in slot 3, bounds and just outside
        e = base();
        e.seq = 16'h0001;
        e.action = IPV4C_ACT_SHUTDOWN;
        e.sport_sel = IPV4C_PORT_RANGE;
        e.sport_lo = 16'h0064;
        e.sport_hi = 16'h00C8;
        wr(3'h3, e, 1'b0);
        frame(8'h06, 32'h0A000033, 32'h01020304, 16'h0064, 8'h05, 1'b1, IPV4C_ACT_SHUTDOWN, 3'h3);
        frame(8'h06, 32'h0A000033, 32'h01020304, 16'h00C8, 8'h05, 1'b1, IPV4C_ACT_SHUTDOWN, 3'h3);
        frame(8'h06, 32'h0A000033, 32'h01020304, 16'h00C9, 8'h05, 1'b1, IPV4C_ACT_PERMIT, 3'h2);
        frame(8'h06, 32'h0A000033, 32'h01020304, 16'h0063, 8'h05, 1'b1, IPV4C_ACT_PERMIT, 3'h2);
        // Range units run out on the fifth range entry
        e = base();
        e.list_id = 8'h09;
        e.sport_sel = IPV4C_PORT_RANGE;
        e.sport_hi = 16'hFFFF;
        for (int i = 4; i < 7; i++) begin
            wr(3'(i), e, 1'b0);
        end
        wr(3'h7, e, 1'b1);
        frame(8'h01, 32'h0, 32'h0, 16'hFFFF, 8'h09, 1'b1, IPV4C_ACT_PERMIT, 3'h4);
        e.sport_sel = IPV4C_PORT_ANY;
        wr(3'h7, e, 1'b0);
        // Top protocol value in slot 0
        e = base();
        e.action = IPV4C_ACT_DENY;
        e.proto_any = 1'b0;
        e.proto = 8'hFF;
        wr(3'h0, e, 1'b0);
        frame(8'hFF, 32'h0A000033, 32'h01020304, 16'h00C9, 8'h05, 1'b1, IPV4C_ACT_DENY, 3'h0);
        frame(8'hFE, 32'h0A000033, 32'h01020304, 16'h00C9, 8'h05, 1'b0, IPV4C_ACT_PERMIT, 3'h0);
        // Counters take the last verdict at the edge that ends its pulse
        @(posedge sys_clk);
        #1;
        chk("forwarded count", 32'(exp_fwd), 32'(fwd_cnt));
        chk("dropped count", 32'(exp_drop), 32'(drop_cnt));
        complete_run();
    end
endmodule
